// ### design/npt_defines.svh
// Constants for the non-volatile page access and timer block.
//
// Summary of operation
// R1 - The block holds a 256-byte array that keeps its contents.
// R2 - Writing a programmed byte ORs the new data in, so a 1 never returns to 0 by writing.
// R3 - Software clears bits by erasing the byte and rewriting it, erase-write being the RAM write.
// R4 - Each erase and each write cycle lasts 5 ms, while a read is as fast as a register read.
// R5 - The array is 64 pages of four bytes and page operations act on all four bytes at once.
// R6 - Single bytes may also be erased and written on their own.
// R7 - The address register advances by itself so sequential bytes need no reload.
// R8 - An 8-bit reloadable down-counter times erase and write and also serves as a timer; the code times erase and write with nv_cnt_r instead.
// R9 - Busy and the mode bits decode to read, increment, write, erase-write, erase or prohibited.
// R10 - Software sets busy to start an erase or write with the timer; the block clears it at the end.
// R11 - The address increments after reads and writes, holds after erases, and wraps past 8 bits.
// R12 - Reading the data port returns the addressed byte; writing it loads the selected page latch.
// R13 - Software starts nothing and changes no mode bits while busy is set.
`ifndef NPT_DEFINES_SVH
`define NPT_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define NPT_IDX_ADDR 6'h01
`define NPT_IDX_DATA 6'h03
`define NPT_IDX_CTRL 6'h04
`define NPT_IDX_RELOAD 6'h05
`define NPT_IDX_TIMER 6'h06
`define NPT_IDX_IRQ_STAT 6'h07
`define NPT_IDX_IRQ_MASK 6'h08

// Control register fields.
`define NPT_CTRL_RUN 7
`define NPT_CTRL_TIE 6
`define NPT_CTRL_TFLAG 5
`define NPT_CTRL_BUSY 4
`define NPT_CTRL_MODE_HI 3
`define NPT_CTRL_MODE_LO 1

// Interrupt status fields.
`define NPT_IRQ_TIMER 0
`define NPT_IRQ_NVDONE 1

// Reset values.
`define NPT_RST_BYTE 8'h00
`define NPT_RST_RELOAD 8'hff

// Timing.
`define NPT_CLK_HZ 50000000
`define NPT_NV_CYCLE_MS 5
`define NPT_NV_CYCLE_CYC ((`NPT_NV_CYCLE_MS * `NPT_CLK_HZ) / 1000)
`define NPT_TICK_US 1
`define NPT_TICK_CYC ((`NPT_TICK_US * `NPT_CLK_HZ) / 1000000)

`endif

// ### design/npt_pkg.sv
// Types shared by the non-volatile page access and timer block.
package npt_pkg;

  typedef enum logic [2:0] {
    NPT_MODE_READ = 3'h0,
    NPT_MODE_BAD1 = 3'h1,
    NPT_MODE_INCR = 3'h2,
    NPT_MODE_WR3 = 3'h3,
    NPT_MODE_ERWR = 3'h4,
    NPT_MODE_BAD5 = 3'h5,
    NPT_MODE_BAD6 = 3'h6,
    NPT_MODE_ERASE = 3'h7
  } npt_mode_type;

  typedef enum logic [1:0] {
    NPT_OP_IDLE,
    NPT_OP_ERASE,
    NPT_OP_WRITE
  } npt_op_type;

endpackage : npt_pkg

// ### design/npt_access_timer.sv
// Non-volatile page access unit with its reloadable down-counter, on AHB-Lite.
`timescale 1ns/1ps
`include "npt_defines.svh"

module npt_access_timer #(
  parameter int NV_CYCLE_CYC = `NPT_NV_CYCLE_CYC,
  parameter int TICK_CYC = `NPT_TICK_CYC
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Interrupt.
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [7:0] mem [0:255]; // R1
  logic [7:0] latch_r [0:3];
  logic [3:0] latch_sel_r;
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic run_r;
  logic tie_r;
  logic tflag_r;
  logic busy_r;
  npt_pkg::npt_mode_type mode_r;
  logic [7:0] reload_r;
  logic [7:0] timer_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  npt_pkg::npt_op_type op_r;
  logic [31:0] nv_cnt_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic t_run;
  logic t_run_d_r;
  logic t_under;
  logic nv_end;
  logic op_done;
  logic wr_phase_r;
  logic [5:0] wr_idx_r;
  logic rd_phase_r;
  logic [5:0] rd_idx_r;
  logic acc;
  logic [5:0] a_idx;
  logic aligned;
  logic wr_ctrl;
  logic wr_data;
  logic rd_data;
  logic rd_stat;
  logic start;
  logic [7:0] ctrl_byte;
  logic [7:0] rd_val;
  logic [7:0] wbyte;
  logic [2:0] wmode;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode. Reads take one wait state so that a read which follows a
  // write sees the written value.

  assign acc = hsel & hready & htrans[1];
  assign aligned = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
  assign a_idx = haddr[7:2];
  assign wbyte = hwdata[7:0];
  assign wmode = wbyte[`NPT_CTRL_MODE_HI:`NPT_CTRL_MODE_LO];
  assign wr_ctrl = wr_phase_r & (wr_idx_r == `NPT_IDX_CTRL);
  assign wr_data = wr_phase_r & (wr_idx_r == `NPT_IDX_DATA) & ~busy_r;
  assign rd_data = rd_phase_r & (rd_idx_r == `NPT_IDX_DATA) & ~busy_r;
  assign rd_stat = rd_phase_r & (rd_idx_r == `NPT_IDX_IRQ_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_phase_r <= 1'b0;
      wr_idx_r <= 6'h00;
    end else begin
      wr_phase_r <= acc & hwrite & aligned;
      wr_idx_r <= a_idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_phase_r <= 1'b0;
      rd_idx_r <= 6'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      rd_phase_r <= acc & ~hwrite;
      rd_idx_r <= aligned ? a_idx : 6'h00;
      hreadyout <= ~(acc & ~hwrite);
      hresp <= 1'b0;
    end
  end

  assign ctrl_byte = {run_r, tie_r, tflag_r, busy_r, mode_r, 1'b0};

  always_comb begin
    rd_val = 8'h00;
    case (rd_idx_r)
      `NPT_IDX_ADDR: rd_val = addr_r;
      `NPT_IDX_DATA: rd_val = busy_r ? 8'h00 : mem[addr_r]; // R12 R4
      `NPT_IDX_CTRL: rd_val = ctrl_byte;
      `NPT_IDX_RELOAD: rd_val = reload_r;
      `NPT_IDX_TIMER: rd_val = timer_r;
      `NPT_IDX_IRQ_STAT: rd_val = {6'h00, irq_stat_r};
      `NPT_IDX_IRQ_MASK: rd_val = {6'h00, irq_mask_r};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_phase_r) begin
      hrdata <= {24'h000000, rd_val};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register. Prohibited modes never start a cycle.

  always_comb begin
    start = 1'b0;
    if (wr_ctrl && !busy_r && wbyte[`NPT_CTRL_BUSY]) begin
      case (wmode) // R9
        3'h2, 3'h3, 3'h4, 3'h7: start = 1'b1;
        default: start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
      tie_r <= 1'b0;
      mode_r <= npt_pkg::NPT_MODE_READ;
    end else if (wr_ctrl) begin
      run_r <= wbyte[`NPT_CTRL_RUN];
      tie_r <= wbyte[`NPT_CTRL_TIE];
      if (!busy_r) begin
        mode_r <= npt_pkg::npt_mode_type'(wmode);
      end
    end
  end

  // Software may set busy; only the end of the cycle clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1; // R10
    end else if (op_done) begin
      busy_r <= 1'b0; // R10
    end
  end

  // Underflow sets the flag even in the cycle that software clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tflag_r <= 1'b0;
    end else if (t_under) begin
      tflag_r <= 1'b1;
    end else if (wr_ctrl) begin
      tflag_r <= wbyte[`NPT_CTRL_TFLAG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Down-counter. It runs while enabled by software or while a cycle is
  // busy, and restarts from the reload value whenever it starts running.

  assign t_run = run_r | busy_r; // R8
  assign tick = (tick_cnt_r == 32'd0);
  assign t_under = t_run & t_run_d_r & tick & (timer_r == 8'h00);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 32'd0;
    end else if (!t_run || tick) begin
      tick_cnt_r <= 32'(TICK_CYC - 1);
    end else begin
      tick_cnt_r <= tick_cnt_r - 32'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t_run_d_r <= 1'b0;
      timer_r <= `NPT_RST_RELOAD;
    end else begin
      t_run_d_r <= t_run;
      if (t_run && !t_run_d_r) begin
        timer_r <= reload_r;
      end else if (t_run && tick) begin
        timer_r <= (timer_r == 8'h00) ? reload_r : timer_r - 8'h01; // R8
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_r <= `NPT_RST_RELOAD;
    end else if (wr_phase_r && wr_idx_r == `NPT_IDX_RELOAD) begin
      reload_r <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Erase and write sequencer. Erase-write runs an erase phase and then a
  // write phase, each one full cycle long.

  assign nv_end = (op_r != npt_pkg::NPT_OP_IDLE) && (nv_cnt_r == 32'd0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_r <= npt_pkg::NPT_OP_IDLE;
      nv_cnt_r <= 32'd0;
    end else begin
      case (op_r)
        npt_pkg::NPT_OP_IDLE: begin
          if (start) begin
            nv_cnt_r <= 32'(NV_CYCLE_CYC - 1); // R4
            if (wmode == 3'h2 || wmode == 3'h3) begin
              op_r <= npt_pkg::NPT_OP_WRITE;
            end else begin
              op_r <= npt_pkg::NPT_OP_ERASE; // R3
            end
          end
        end
        npt_pkg::NPT_OP_ERASE: begin
          if (nv_end) begin
            nv_cnt_r <= 32'(NV_CYCLE_CYC - 1); // R4
            if (mode_r == npt_pkg::NPT_MODE_ERWR) begin
              op_r <= npt_pkg::NPT_OP_WRITE;
            end else begin
              op_r <= npt_pkg::NPT_OP_IDLE;
            end
          end else begin
            nv_cnt_r <= nv_cnt_r - 32'd1;
          end
        end
        npt_pkg::NPT_OP_WRITE: begin
          if (nv_end) begin
            op_r <= npt_pkg::NPT_OP_IDLE;
          end else begin
            nv_cnt_r <= nv_cnt_r - 32'd1;
          end
        end
        default: op_r <= npt_pkg::NPT_OP_IDLE;
      endcase
    end
  end

  assign op_done = nv_end & ~((op_r == npt_pkg::NPT_OP_ERASE) &
                              (mode_r == npt_pkg::NPT_MODE_ERWR));

  // Only bytes whose latch was loaded take part; with none loaded the whole
  // page does, so single bytes and whole pages share one mechanism.
  always_ff @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      if (nv_end && (latch_sel_r[i] || latch_sel_r == 4'h0)) begin
        if (op_r == npt_pkg::NPT_OP_ERASE) begin
          mem[{addr_r[7:2], 2'(i)}] <= 8'h00; // R5 R6
        end else if (op_r == npt_pkg::NPT_OP_WRITE) begin
          mem[{addr_r[7:2], 2'(i)}] <= mem[{addr_r[7:2], 2'(i)}] | latch_r[i]; // R2 R5 R6
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_sel_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        latch_r[i] <= `NPT_RST_BYTE;
      end
    end else if (op_done) begin
      latch_sel_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        latch_r[i] <= `NPT_RST_BYTE;
      end
    end else if (wr_data) begin
      latch_r[addr_r[1:0]] <= wbyte; // R12
      latch_sel_r[addr_r[1:0]] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address register.

  always_comb begin
    addr_nxt = addr_r;
    if (wr_phase_r && wr_idx_r == `NPT_IDX_ADDR && !busy_r) begin
      addr_nxt = wbyte;
    end else if (op_done && op_r == npt_pkg::NPT_OP_WRITE) begin
      addr_nxt = addr_r + 8'h01; // R11 R7
    end else if (rd_data) begin
      addr_nxt = addr_r + 8'h01; // R11 R7
    end else if (wr_data && mode_r == npt_pkg::NPT_MODE_INCR && addr_r[1:0] != 2'b11) begin
      addr_nxt = {addr_r[7:2], addr_r[1:0] + 2'b01}; // R7
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= `NPT_RST_BYTE;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts. Events win over the clearing read.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= 2'b00;
    end else begin
      irq_stat_r[`NPT_IRQ_TIMER] <= t_under | (irq_stat_r[`NPT_IRQ_TIMER] & ~rd_stat);
      irq_stat_r[`NPT_IRQ_NVDONE] <= op_done | (irq_stat_r[`NPT_IRQ_NVDONE] & ~rd_stat);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_r <= 2'b00;
    end else if (wr_phase_r && wr_idx_r == `NPT_IDX_IRQ_MASK) begin
      irq_mask_r <= wbyte[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= (|(irq_stat_r & irq_mask_r)) | (tflag_r & tie_r);
    end
  end

endmodule : npt_access_timer

// ### tb/npt_bus_monitor.sv
// Bus timing checker for the access timer block.
`timescale 1ns/1ps
module npt_bus_monitor #(
  parameter int NV_CYCLE_CYC = 20,
  parameter int TICK_CYC = 2
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_t;
  logic wr_t;
  assign rd_t = hsel && hready && htrans[1] && !hwrite;
  assign wr_t = hsel && hready && htrans[1] && hwrite;
  ////////////////////////////////////////
  resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a: assert property (rd_t |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (wr_t |=> hreadyout) else $error("write stalled");
  wait_short_a: assert property (!hreadyout |=> hreadyout) else $error("wait too long");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_t))
    else $error("wait without read");
  rdata_upper_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  unmap_zero_a: assert property (rd_t && haddr[31:8] != 24'h0 |=> ##1 hrdata == 32'h0)
    else $error("unmapped read not zero");
  cover property (rd_t);
  cover property (wr_t);
  cover property ($rose(irq));
endmodule : npt_bus_monitor

// ### tb/npt_cpu_model.sv
// CPU side bus master model issuing single word transfers.
`timescale 1ns/1ps
module npt_cpu_model (
  // Clock and answer.
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Request.
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Released lines show inverted values so stale data never looks valid.
  task xfer(input logic [31:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata[7:0];
    hwdata <= ~{24'h0, d};
  endtask : xfer
endmodule : npt_cpu_model

// ### tb/tb_npt_access_timer.sv
// Self-checking bench for the access timer block.
`timescale 1ns/1ps
module tb_npt_access_timer;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] got, v;
  logic [7:0] d [4];
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int num_checks = 0;
  event got_ev;
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  npt_cpu_model u_npt_cpu_model (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  npt_access_timer #(.NV_CYCLE_CYC(20), .TICK_CYC(2)) u_npt_access_timer (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irq(irq));
  ////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [7:0] x);
    u_npt_cpu_model.xfer(a, 1'b1, x, v);
  endtask : wr
  task rdc(input logic [31:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_npt_cpu_model.xfer(a, 1'b0, 8'h00, got);
    ->got_ev;
  endtask : rdc
  // Software must not touch the cycle while busy, so it polls first.
  task wait_idle;
    for (int i = 0; i < 100; i++) begin
      u_npt_cpu_model.xfer(32'h10, 1'b0, 8'h00, v);
      if (v[4] === 1'b0) break;
    end
    chk("busy", 8'h00, {7'h0, v[4]});
  endtask : wait_idle
  task final_report;
    if (exp_q.size() != 0) error_cnt++;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(got_ev) chk("read data", exp_q.pop_front(), got);
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    final_report();
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hb2f8));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(32'h14, 8'hff);
    rdc(32'h04, 8'h00);
    wr(32'h04, 8'hfc);
    wr(32'h10, 8'h1e);
    wait_idle();
    rdc(32'h04, 8'hfc);
    wr(32'h04, 8'hff);
    rdc(32'h0c, 8'h00);
    rdc(32'h04, 8'h00);
    rdc(32'h1c, 8'h02);
    wr(32'h10, 8'h04);
    wr(32'h04, 8'h10);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($urandom);
      wr(32'h0c, d[i]);
    end
    rdc(32'h04, 8'h13);
    wr(32'h20, 8'h02);
    wr(32'h10, 8'h18);
    wait_idle();
    chk("irq", 8'h01, {7'h0, irq});
    rdc(32'h1c, 8'h02);
    repeat (3) @(posedge hclk);
    chk("irq", 8'h00, {7'h0, irq});
    rdc(32'h04, 8'h14);
    wr(32'h04, 8'h10);
    for (int i = 0; i < 4; i++) rdc(32'h0c, d[i]);
    wr(32'h04, 8'h11);
    wr(32'h0c, 8'h0f);
    wr(32'h10, 8'h16);
    wait_idle();
    wr(32'h04, 8'h10);
    rdc(32'h0c, d[0]);
    rdc(32'h0c, d[1] | 8'h0f);
    wr(32'h04, 8'h12);
    wr(32'h0c, 8'h00);
    wr(32'h10, 8'h1e);
    rdc(32'h0c, 8'h00);
    wait_idle();
    rdc(32'h04, 8'h12);
    rdc(32'h0c, 8'h00);
    rdc(32'h0c, d[3]);
    rdc(32'h1c, 8'h02);
    wr(32'h10, 8'h12);
    repeat (40) @(posedge hclk);
    rdc(32'h1c, 8'h00);
    rdc(32'h10, 8'h02);
    wr(32'h14, 8'h03);
    wr(32'h10, 8'hc0);
    repeat (40) @(posedge hclk);
    chk("irq", 8'h01, {7'h0, irq});
    rdc(32'h1c, 8'h01);
    rdc(32'h104, 8'h00);
    wr(32'h10, 8'h00);
    repeat (3) @(posedge hclk);
    chk("irq", 8'h00, {7'h0, irq});
    wr(32'h40, 8'haa);
    rdc(32'h40, 8'h00);
    // Let the compare process take the last result before the verdict.
    @(posedge hclk);
    final_report();
  end
endmodule : tb_npt_access_timer
bind npt_access_timer npt_bus_monitor #(.NV_CYCLE_CYC(NV_CYCLE_CYC), .TICK_CYC(TICK_CYC))
  u_npt_bus_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .irq(irq));
